//--- misc_cfg_pkg.sv
`default_nettype none
package misc_cfg_pkg;
    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [7:0] MISC_HOST_CONFIG_OFS = 8'hF0;
    localparam logic [7:0] PM_CAP_DWORD_OFS = 8'h44;
    localparam logic [31:0] MISC_HOST_CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] MISC_WRITABLE_MASK = 32'h0000_801F;
    localparam int COLD_WAKE_SUPPORT_BIT = 15;
    localparam int PM_CAP_COLD_WAKE_BIT = 31;
    localparam int ABORT_SUPPRESS_MODE_BIT = 4;
    localparam int PINS_TO_TWOWIRE_ROUTE_BIT = 3;
    localparam int LINK_CLOCK_GATE_BYPASS_BIT = 2;
    localparam int HOST_CLOCK_GATE_BYPASS_BIT = 1;
    localparam int KEEP_HOST_CLOCK_BIT = 0;
    localparam logic [31:0] ALL_ONES_DATA = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_DATA = 32'h0000_0000;
    // ************************************************************
    // Clock-run timing
    // ************************************************************
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int CLKRUN_DRIVE_CYCLES = 2;
    localparam logic [1:0] CLKRUN_CNT_LAST = 2'(CLKRUN_DRIVE_CYCLES - 1);

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
    } link_req_t;

    typedef enum logic [1:0] {
        CR_IDLE = 2'b00,
        CR_DRIVE = 2'b01,
        CR_RELEASE = 2'b10
    } clkrun_state_t;
endpackage
`default_nettype wire

//--- misc_pci_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module misc_pci_config_register
    import misc_cfg_pkg::*;
(
    input wire logic ref_clk_i, // Host bus clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic ce_i, // Clock enable; state frozen while low.
    input wire cfg_req_t cfg_req_i, // Configuration access request.
    output logic [31:0] cfg_rdata_o, // Configuration read data.
    output logic cfg_ack_o, // Configuration access done pulse.
    output logic pm_cap_cold_wake_o, // Config bit 15, shown as bit 31 of the capabilities word.
    input wire link_req_t link_req_i, // Host access to a link register.
    input wire logic [31:0] link_rdata_i, // Read data from the link domain.
    output logic [31:0] link_rdata_o, // Read data returned to the host.
    output logic link_done_o, // Link access completed normally.
    output logic link_abort_o, // Link access ends in target abort.
    output logic link_write_en_o, // Write passed to the link domain.
    input wire logic link_clk_gate_en_i, // Link clock gate is open.
    output logic link_domain_active_o, // Link clock domain is running.
    output logic link_clock_gate_bypass_o, // Internal link clock follows pin.
    output logic host_clock_gate_bypass_o, // Internal host clock follows pin.
    input wire logic general_pin_three_i, // Pad level of general pin three.
    input wire logic general_pin_two_i, // Pad level of general pin two.
    input wire logic pin_three_drive_i, // General pin three drive value.
    input wire logic pin_three_drive_en_i, // General pin three drive enable.
    input wire logic pin_two_drive_i, // General pin two drive value.
    input wire logic pin_two_drive_en_i, // General pin two drive enable.
    output logic general_pin_three_o, // Pad output of pin three.
    output logic general_pin_three_oe_o, // Pad drive enable of pin three.
    output logic general_pin_two_o, // Pad output of pin two.
    output logic general_pin_two_oe_o, // Pad drive enable of pin two.
    output logic pin_three_level_o, // Pin three level seen by the GPIO logic.
    output logic pin_two_level_o, // Pin two level seen by the GPIO logic.
    output logic twowire_scl_in_o, // Clock line seen by the two-wire logic.
    output logic twowire_sda_in_o, // Data line seen by the two-wire logic.
    output logic pins_to_twowire_route_o, // Pins are routed to two-wire.
    input wire logic clkrun_n_i, // Clock-run line level.
    input wire logic host_clock_need_i, // Device logic needs the host clock.
    output logic clkrun_n_o, // Clock-run drive value.
    output logic clkrun_oe_o // Clock-run drive enable.
);
    // ************************************************************
    // Register storage and decode
    // ************************************************************
    logic [31:0] misc_host_config;
    logic [31:0] next_misc_host_config;
    logic [31:0] rdata_sel;
    logic [31:0] be_mask;
    logic hit_misc;
    logic hit_pm_cap;
    logic abort_suppress_mode;
    logic keep_host_clock;

    function automatic logic [31:0] expand_be(input logic [3:0] be);
        expand_be = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    assign hit_misc = (cfg_req_i.addr[7:2] == MISC_HOST_CONFIG_OFS[7:2]);
    assign hit_pm_cap = (cfg_req_i.addr[7:2] == PM_CAP_DWORD_OFS[7:2]);
    // Only the six writable fields take data; the rest stay zero.
    assign be_mask = expand_be(cfg_req_i.be) & MISC_WRITABLE_MASK;
    assign next_misc_host_config = (misc_host_config & ~be_mask) | (cfg_req_i.wdata & be_mask);

    assign abort_suppress_mode = misc_host_config[ABORT_SUPPRESS_MODE_BIT];
    assign keep_host_clock = misc_host_config[KEEP_HOST_CLOCK_BIT];

    // The capabilities word itself lives elsewhere; only its wake bit is offered here.
    assign pm_cap_cold_wake_o = misc_host_config[COLD_WAKE_SUPPORT_BIT];

    always_comb begin
        rdata_sel = ZERO_DATA;
        if (hit_misc) begin
            rdata_sel = misc_host_config & MISC_WRITABLE_MASK;
        end else if (hit_pm_cap) begin
            rdata_sel[PM_CAP_COLD_WAKE_BIT] = misc_host_config[COLD_WAKE_SUPPORT_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            misc_host_config <= MISC_HOST_CONFIG_RST;
        end else if (ce_i && cfg_req_i.wr && hit_misc) begin
            misc_host_config <= next_misc_host_config;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= ZERO_DATA;
            cfg_ack_o <= 1'b0;
        end else if (ce_i) begin
            cfg_ack_o <= cfg_req_i.rd | cfg_req_i.wr;
            if (cfg_req_i.rd) begin
                cfg_rdata_o <= rdata_sel;
            end
        end
    end

    // ************************************************************
    // Clock gates and link domain status
    // ************************************************************
    assign link_clock_gate_bypass_o = misc_host_config[LINK_CLOCK_GATE_BYPASS_BIT];
    assign host_clock_gate_bypass_o = misc_host_config[HOST_CLOCK_GATE_BYPASS_BIT];
    // A bypassed gate means the link clock runs whatever the gate asks for.
    assign link_domain_active_o = link_clk_gate_en_i | link_clock_gate_bypass_o;

    // ************************************************************
    // Link register access answer
    // ************************************************************
    logic link_any;
    logic link_dead;
    assign link_any = link_req_i.rd | link_req_i.wr;
    assign link_dead = link_any && !link_domain_active_o;
    // Writes to a stopped domain would be lost in the gate, so they are dropped here.
    assign link_write_en_o = link_req_i.wr && link_domain_active_o;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_done_o <= 1'b0;
            link_abort_o <= 1'b0;
            link_rdata_o <= ZERO_DATA;
        end else if (ce_i) begin
            link_abort_o <= link_dead && !abort_suppress_mode;
            link_done_o <= link_any && (link_domain_active_o || abort_suppress_mode);
            if (link_req_i.rd) begin
                link_rdata_o <= link_domain_active_o ? link_rdata_i : ALL_ONES_DATA;
            end
        end
    end

    // ************************************************************
    // General pin routing
    // ************************************************************
    assign pins_to_twowire_route_o = misc_host_config[PINS_TO_TWOWIRE_ROUTE_BIT];
    assign twowire_scl_in_o = pins_to_twowire_route_o & general_pin_three_i;
    assign twowire_sda_in_o = pins_to_twowire_route_o & general_pin_two_i;
    assign pin_three_level_o = !pins_to_twowire_route_o & general_pin_three_i;
    assign pin_two_level_o = !pins_to_twowire_route_o & general_pin_two_i;
    assign general_pin_three_o = pin_three_drive_i;
    assign general_pin_two_o = pin_two_drive_i;
    assign general_pin_three_oe_o = pin_three_drive_en_i && !pins_to_twowire_route_o;
    assign general_pin_two_oe_o = pin_two_drive_en_i && !pins_to_twowire_route_o;

    // ************************************************************
    // Clock-run request
    // ************************************************************
    clkrun_state_t cr_state;
    clkrun_state_t next_cr_state;
    logic [1:0] cr_cnt;
    logic want_clock;
    // The master raises the line to announce a stop; pulling it low vetoes that.
    assign want_clock = keep_host_clock | host_clock_need_i;

    always_comb begin
        next_cr_state = cr_state;
        case (cr_state)
            CR_IDLE: begin
                if (clkrun_n_i && want_clock) begin
                    next_cr_state = CR_DRIVE;
                end
            end
            CR_DRIVE: begin
                if (cr_cnt == CLKRUN_CNT_LAST) begin
                    next_cr_state = CR_RELEASE;
                end
            end
            CR_RELEASE: begin
                next_cr_state = CR_IDLE;
            end
            default: begin
                next_cr_state = CR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cr_state <= CR_IDLE;
            cr_cnt <= 2'h0;
        end else if (ce_i) begin
            cr_state <= next_cr_state;
            cr_cnt <= (cr_state == CR_DRIVE) ? cr_cnt + 2'h1 : 2'h0;
        end
    end

    // Released for one cycle after driving, so the line is never held across a stop.
    assign clkrun_n_o = 1'b0;
    assign clkrun_oe_o = (cr_state == CR_DRIVE);

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_cfg_write_misc;
        ce_i && cfg_req_i.wr && hit_misc;
    endsequence

    sequence s_dead_access;
        ce_i && link_dead;
    endsequence

    a_reserved_high_zero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        misc_host_config[31:16] == 16'h0000)
        else $error("upper half of config register not zero");

    a_reserved_mid_zero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_cfg_write_misc ##1 (ce_i && cfg_req_i.rd && hit_misc) |=> cfg_rdata_o[14:5] == 10'h000)
        else $error("reserved middle bits read nonzero");

    a_cold_wake_mirror: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && cfg_req_i.rd && hit_pm_cap)
        |=> cfg_rdata_o[PM_CAP_COLD_WAKE_BIT] == $past(pm_cap_cold_wake_o))
        else $error("capabilities wake bit does not follow config bit");

    a_abort_when_off: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_dead_access and (!abort_suppress_mode) |=> link_abort_o && !link_done_o)
        else $error("no target abort on access to stopped link domain");

    a_suppress_completes: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_dead_access and abort_suppress_mode |=> link_done_o && !link_abort_o)
        else $error("suppressed access did not complete normally");

    a_ones_when_off: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && link_req_i.rd && !link_domain_active_o && abort_suppress_mode)
        |=> link_rdata_o == ALL_ONES_DATA)
        else $error("stopped link read did not return all ones");

    a_route_release: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pins_to_twowire_route_o |-> !general_pin_three_oe_o && !general_pin_two_oe_o)
        else $error("rerouted pin still driven");

    a_route_lines: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pins_to_twowire_route_o |-> twowire_scl_in_o == general_pin_three_i
        && twowire_sda_in_o == general_pin_two_i && !pin_three_level_o && !pin_two_level_o)
        else $error("two-wire lines not fed from the general pins");

    a_keep_clock_veto: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && cr_state == CR_IDLE && clkrun_n_i && keep_host_clock)
        |=> clkrun_oe_o ##1 clkrun_oe_o)
        else $error("stop request not vetoed for two cycles");

    a_no_veto_idle: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cr_state == CR_IDLE && !keep_host_clock && !host_clock_need_i) |=> !clkrun_oe_o)
        else $error("clock-run driven without a reason");

    a_reset_no_suppress: assert property (
        @(posedge ref_clk_i)
        $rose(rst_n_i) |-> !abort_suppress_mode)
        else $error("abort suppression set after reset");

    a_link_active_flag: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (link_clk_gate_en_i || link_clock_gate_bypass_o) == link_domain_active_o)
        else $error("link domain status wrong");

    a_host_bypass_bit: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_cfg_write_misc and cfg_req_i.be[0]
        |=> host_clock_gate_bypass_o == $past(cfg_req_i.wdata[HOST_CLOCK_GATE_BYPASS_BIT]))
        else $error("host clock gate bypass did not take written value");
endmodule
`default_nettype wire

//--- misc_host_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Host side stand-in: clock-run line and link domain data
// ************************************************************
module misc_host_partner (
    input wire logic ref_clk_i, // Host bus clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic clkrun_oe_i, // Device drives clock-run.
    input wire logic clkrun_drv_i, // Device drive value.
    output logic clkrun_line_o, // Resolved clock-run line.
    output logic [31:0] link_data_o // Link domain read data.
);
    // The host always wants to stop the clock, so the line rests high on its pull-up.
    assign clkrun_line_o = clkrun_oe_i ? clkrun_drv_i : 1'h1;
    // A new word every cycle, so stale read data never passes for fresh.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_data_o <= 32'h1357_9BDF;
        end else begin
            link_data_o <= {link_data_o[30:0], link_data_o[31] ^ link_data_o[21] ^ link_data_o[1]};
        end
    end
endmodule
`default_nettype wire

//--- test_misc_pci_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module test_misc_pci_config_register
    import misc_cfg_pkg::*;
;
    typedef struct packed {
        logic [1:0] kind;
        logic chk;
        logic [31:0] data;
    } note_t;
    note_t notes[$];
    note_t note;
    int fails = 0;
    int comparisons = 0;
    logic ref_clk, rst_n = 1'h0, gate_en = 1'h0, ce = 1'h1, need = 1'h0;
    cfg_req_t cfg_req = '0;
    link_req_t link_req = '0;
    logic ext3 = 1'h0, ext2 = 1'h0, g3o = 1'h0, g3e = 1'h0, g2o = 1'h0, g2e = 1'h0;
    logic [7:0] seed = 8'h1E;
    logic r, e3, e2, p3, p2;
    logic [31:0] cfg_rdata, link_rdata, link_data;
    logic cfg_ack, cold_wake, link_done, link_abort, link_we, link_active, link_bypass;
    logic host_bypass, pin3_o, pin3_oe, pin2_o, pin2_oe, pin3_lvl, pin2_lvl, scl_in, sda_in;
    logic route, clkrun_line, clkrun_drv, clkrun_oe;
    wire logic pad3 = pin3_oe ? pin3_o : ext3;
    wire logic pad2 = pin2_oe ? pin2_o : ext2;

    misc_pci_config_register i_misc_pci_config_register (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .cfg_req_i(cfg_req),
        .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .pm_cap_cold_wake_o(cold_wake),
        .link_req_i(link_req), .link_rdata_i(link_data), .link_rdata_o(link_rdata),
        .link_done_o(link_done), .link_abort_o(link_abort), .link_write_en_o(link_we),
        .link_clk_gate_en_i(gate_en), .link_domain_active_o(link_active),
        .link_clock_gate_bypass_o(link_bypass), .host_clock_gate_bypass_o(host_bypass),
        .general_pin_three_i(pad3), .general_pin_two_i(pad2), .pin_three_drive_i(g3o),
        .pin_three_drive_en_i(g3e), .pin_two_drive_i(g2o), .pin_two_drive_en_i(g2e),
        .general_pin_three_o(pin3_o),
        .general_pin_three_oe_o(pin3_oe), .general_pin_two_o(pin2_o),
        .general_pin_two_oe_o(pin2_oe), .pin_three_level_o(pin3_lvl),
        .pin_two_level_o(pin2_lvl),
        .twowire_scl_in_o(scl_in), .twowire_sda_in_o(sda_in), .pins_to_twowire_route_o(route),
        .clkrun_n_i(clkrun_line), .host_clock_need_i(need), .clkrun_n_o(clkrun_drv),
        .clkrun_oe_o(clkrun_oe));

    misc_host_partner i_misc_host_partner (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .clkrun_oe_i(clkrun_oe),
        .clkrun_drv_i(clkrun_drv), .clkrun_line_o(clkrun_line), .link_data_o(link_data));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // The request is left standing so that calls run back to back; idle ends a burst.
    task automatic cfg_op(input logic rd, input logic wr, input logic [7:0] addr,
        input logic [3:0] be, input logic [31:0] wdata, input logic [31:0] expd);
        cfg_req = '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
        notes.push_back('{kind: 2'h0, chk: rd, data: expd});
        @(negedge ref_clk);
    endtask

    task automatic idle();
        cfg_req = '0;
        link_req = '0;
        @(negedge ref_clk);
    endtask

    task automatic count_oe(input int n_exp);
        int n = 0;
        repeat (8) begin
            @(negedge ref_clk);
            n += int'(clkrun_oe === 1'h1);
        end
        check(35'(n), 35'(n_exp));
    endtask

    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Answer monitor
    // ************************************************************
    always @(negedge ref_clk) begin
        if (rst_n && (cfg_ack === 1'h1 || link_done === 1'h1 || link_abort === 1'h1)) begin
            note = (notes.size() == 0) ? note_t'{kind: 2'h3, chk: 1'h0, data: 32'h0}
                : notes.pop_front();
            check({cfg_ack, link_done, link_abort, note.chk ? (note.kind == 2'h0 ? cfg_rdata :
                link_rdata) : 32'h0}, {note.kind == 2'h0, note.kind == 2'h1, note.kind == 2'h2,
                note.chk ? note.data : 32'h0});
        end
    end

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #(5000 * 100);
        fails++;
        finish_test();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_n = 1'h1;
        cfg_op(1'h1, 1'h0, 8'hF0, 4'hF, 32'h0, 32'h0);
        cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, 32'hFFFF_FFFF, 32'h0);
        cfg_op(1'h1, 1'h0, 8'hF0, 4'hF, 32'h0, 32'h0000_801F);
        cfg_op(1'h1, 1'h0, 8'h44, 4'hF, 32'h0, 32'h8000_0000);
        idle();
        check(35'({cold_wake, link_bypass, host_bypass, route, link_active}),
            35'h1F);
        cfg_op(1'h0, 1'h1, 8'hF0, 4'h1, 32'h0, 32'h0);
        cfg_op(1'h0, 1'h1, 8'hF4, 4'hF, 32'hFFFF_FFFF, 32'h0);
        cfg_op(1'h1, 1'h0, 8'hF0, 4'hF, 32'h0, 32'h0000_8000);
        cfg_op(1'h1, 1'h0, 8'h10, 4'hF, 32'h0, 32'h0);
        cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, 32'h0, 32'h0);
        cfg_op(1'h1, 1'h0, 8'h44, 4'hF, 32'h0, 32'h0);
        idle();
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, {27'h0, i[0], 4'h0}, 32'h0);
            cfg_req = '0;
            gate_en = i[1];
            link_req = '{rd: ~i[2], wr: i[2]};
            #1;
            check(35'(link_we), 35'(i[2] & i[1]));
            check(35'(link_active), 35'(i[1]));
            notes.push_back('{kind: (i[1] | i[0]) ? 2'h1 : 2'h2, chk: ~i[2],
                data: i[1] ? link_data : 32'hFFFF_FFFF});
            @(negedge ref_clk);
            idle();
        end
        $display("test link access done");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            r = seed[6];
            {ext3, ext2, g3o, g3e, g2o, g2e} = seed[5:0];
            cfg_op(1'h0, 1'h1, 8'hF0, 4'h1, {28'h0, r, 3'h0}, 32'h0);
            idle();
            e3 = g3e & ~r;
            e2 = g2e & ~r;
            p3 = e3 ? g3o : ext3;
            p2 = e2 ? g2o : ext2;
            check(35'({pin3_oe, pin3_o, pin3_lvl, scl_in, pin2_oe, pin2_o, pin2_lvl, sda_in}),
                35'({e3, g3o, p3 & ~r, p3 & r, e2, g2o, p2 & ~r, p2 & r}));
        end
        $display("test pin routing done");
        cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, 32'h1, 32'h0);
        idle();
        count_oe(4);
        cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, 32'h0, 32'h0);
        repeat (3) idle();
        count_oe(0);
        need = 1'h1;
        count_oe(4);
        need = 1'h0;
        $display("test clock run done");
        // With the clock enable low a write must neither land nor be answered.
        ce = 1'h0;
        cfg_req = '{rd: 1'h0, wr: 1'h1, addr: 8'hF0, be: 4'hF, wdata: 32'h0000_8000};
        @(negedge ref_clk);
        check(35'({cfg_ack, cold_wake}), 35'h0);
        ce = 1'h1;
        idle();
        cfg_op(1'h0, 1'h1, 8'hF0, 4'hF, 32'h10, 32'h0);
        idle();
        rst_n = 1'h0;
        idle();
        rst_n = 1'h1;
        cfg_op(1'h1, 1'h0, 8'hF0, 4'hF, 32'h0, 32'h0);
        idle();
        idle();
        check(35'(notes.size()), 35'h0);
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
